// >>> bpl_pkg.sv
`default_nettype none
package bpl_pkg;
  // Clock rate and nominal bit timing.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HOST_BIT_PERIOD_US = 1024;
  localparam int unsigned REPLY_BIT_PERIOD_US = 1024;
  // Half bit time as a fraction of the host bit period, in percent.
  localparam int unsigned HALF_BIT_PCT = 50;
  localparam int unsigned HOST_BIT_CYC = (CLK_HZ / 1_000_000) * HOST_BIT_PERIOD_US;
  localparam int unsigned REPLY_BIT_CYC = (CLK_HZ / 1_000_000) * REPLY_BIT_PERIOD_US;
  localparam int unsigned HALF_BIT_CYC = HOST_BIT_CYC * HALF_BIT_PCT / 100;
  // Word width carried by the link and FIFO depth.
  localparam int unsigned WORD_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  // Receive mode states.
  typedef enum logic [1:0] {
    BPL_APP = 2'b00,
    BPL_PROG = 2'b01
  } bpl_mode_t;
endpackage : bpl_pkg
`default_nettype wire

// >>> bpl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bpl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic push, pop, full, empty;

  // Pointers carry one extra bit so full and empty are distinct.
  always_comb begin
    full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
    empty = (wr_ff == rd_ff);
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    in_ready_o = !full;
    out_valid_o = !empty;
    out_data_o = mem_ff[rd_ff[AW-1:0]];
  end

  // Pointer and storage registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule : bpl_fifo
`default_nettype wire

// >>> bpl_link.sv
`timescale 1ns/1ps
`default_nettype none
module bpl_link
  import bpl_pkg::*;
#(
  parameter int unsigned W = WORD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned HOST_CYC = HOST_BIT_CYC,
  parameter int unsigned REPLY_CYC = REPLY_BIT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic lock_nv_i,
  input wire logic prog_pulse_i,
  input wire logic rx_line_i,
  output logic tx_line_o,
  output logic tx_drive_o,
  output logic prog_mode_o,
  output logic lock_pending_o,
  input wire logic lock_write_i,
  output logic [W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] diag_i,
  output logic [7:0] diag_o,
  output logic [7:0] rx_err_cnt_o
);
  localparam int unsigned HALF_CYC = HOST_CYC * HALF_BIT_PCT / 100;
  localparam int unsigned RCW = $clog2(2 * HOST_CYC + 1);
  localparam int unsigned BW = $clog2(W + 1);
  // Edge windows: mid edge accepted from 1/4 to 3/4, boundary after 3/4 to 5/4.
  localparam logic [RCW-1:0] MID_LO = RCW'(HALF_CYC / 2);
  localparam logic [RCW-1:0] MID_HI = RCW'(HALF_CYC + HALF_CYC / 2);
  localparam logic [RCW-1:0] BND_HI = RCW'(HOST_CYC + HALF_CYC / 2);
  localparam logic [RCW-1:0] TX_HALF = RCW'(REPLY_CYC * HALF_BIT_PCT / 100);
  localparam logic [RCW-1:0] TX_FULL = RCW'(REPLY_CYC);

  // Saturating increment used by both bit timers.
  function automatic logic [RCW-1:0] tick(input logic [RCW-1:0] c);
    tick = (c == '1) ? c : c + 1'b1;
  endfunction : tick

  // Mode and lock state.
  bpl_mode_t mode_ff, nxt_mode;
  logic lock_pend_ff, nxt_lock_pend;
  logic lock_live_ff, nxt_lock_live;
  logic lock_eff;
  logic [7:0] diag_ff, nxt_diag;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_lock_pend = lock_pend_ff | lock_write_i;
    nxt_lock_live = lock_eff;
    nxt_diag = diag_i;
    if (mode_ff == BPL_APP && prog_pulse_i && !lock_live_ff) begin
      nxt_mode = BPL_PROG;
    end
  end

  // Reset stands for power-up: application mode, lock sampled from memory.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_ff <= BPL_APP;
      lock_pend_ff <= 1'b0;
      lock_live_ff <= 1'b1; // Blocked until the stored lock has been captured.
      diag_ff <= 8'h00;
    end else begin
      mode_ff <= nxt_mode;
      lock_pend_ff <= nxt_lock_pend;
      lock_live_ff <= nxt_lock_live;
      diag_ff <= nxt_diag;
    end
  end

  // The live lock is captured once, just after reset release.
  logic cap_done_ff, nxt_cap_done;
  always_comb begin
    nxt_cap_done = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cap_done_ff <= 1'b0;
    end else begin
      cap_done_ff <= nxt_cap_done;
    end
  end
  logic lock_cap_ff;
  always_ff @(posedge clk_i) begin
    if (!cap_done_ff) begin
      lock_cap_ff <= lock_nv_i;
    end
  end
  // Lock blocks the pulse only once captured; until then none is honoured.
  always_comb begin
    lock_eff = lock_cap_ff | !cap_done_ff;
  end

  // Receive decoder state.
  logic rx_prev_ff, nxt_rx_prev;
  logic [RCW-1:0] rcnt_ff, nxt_rcnt;
  logic rmid_ff, nxt_rmid;
  logic rsync_ff, nxt_rsync;
  logic [W-1:0] rsh_ff, nxt_rsh;
  logic [BW-1:0] rbits_ff, nxt_rbits;
  logic [7:0] rerr_ff, nxt_rerr;
  logic rpush;
  logic [W-1:0] rword;
  logic rx_in_ready;
  logic edge_seen, take_bit, bit_val;

  always_comb begin
    nxt_rx_prev = rx_line_i;
    edge_seen = rx_line_i != rx_prev_ff;
    nxt_rcnt = tick(rcnt_ff);
    nxt_rmid = rmid_ff;
    nxt_rsync = rsync_ff;
    nxt_rsh = rsh_ff;
    nxt_rbits = rbits_ff;
    nxt_rerr = rerr_ff;
    take_bit = 1'b0;
    bit_val = 1'b0;
    rpush = 1'b0;
    rword = rsh_ff;
    if (mode_ff != BPL_PROG) begin
      nxt_rsync = 1'b0;
      nxt_rcnt = '0;
    end else if (edge_seen) begin
      if (!rsync_ff) begin
        nxt_rsync = 1'b1; // First edge opens the first bit period.
        nxt_rcnt = '0;
        nxt_rmid = 1'b0;
      end else if (rcnt_ff >= MID_LO && rcnt_ff < MID_HI && !rmid_ff) begin
        nxt_rmid = 1'b1;
      end else if (rcnt_ff >= MID_HI && rcnt_ff < BND_HI) begin
        take_bit = 1'b1;
        bit_val = rmid_ff;
        nxt_rcnt = '0;
        nxt_rmid = 1'b0;
      end else begin
        nxt_rerr = rerr_ff + 8'h01; // Edge outside every window, or a second edge in the mid window.
        nxt_rsync = 1'b0;
        nxt_rbits = '0;
      end
    end else if (rsync_ff && rcnt_ff >= BND_HI) begin
      nxt_rsync = 1'b0; // Line idle: telegram over, drop a partial word.
      nxt_rbits = '0;
    end
    if (take_bit) begin
      nxt_rsh = {rsh_ff[W-2:0], bit_val}; // MSB first.
      if (rbits_ff == BW'(W - 1)) begin
        nxt_rbits = '0;
        rword = {rsh_ff[W-2:0], bit_val};
        rpush = 1'b1;
        if (!rx_in_ready) begin
          nxt_rerr = rerr_ff + 8'h01; // Overflow counts as an error.
        end
      end else begin
        nxt_rbits = rbits_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_prev_ff <= 1'b1;
      rcnt_ff <= '0;
      rmid_ff <= 1'b0;
      rsync_ff <= 1'b0;
      rsh_ff <= '0;
      rbits_ff <= '0;
      rerr_ff <= 8'h00;
    end else begin
      rx_prev_ff <= nxt_rx_prev;
      rcnt_ff <= nxt_rcnt;
      rmid_ff <= nxt_rmid;
      rsync_ff <= nxt_rsync;
      rsh_ff <= nxt_rsh;
      rbits_ff <= nxt_rbits;
      rerr_ff <= nxt_rerr;
    end
  end

  // Received words queue for the memory side.
  logic [W-1:0] rq_data;
  logic rq_valid;
  bpl_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(rword),
    .in_valid_i(rpush),
    .in_ready_o(rx_in_ready),
    .out_data_o(rq_data),
    .out_valid_o(rq_valid),
    .out_ready_i(rx_ready_i && !rx_valid_o)
  );

  // Output register stage for the receive stream.
  logic [W-1:0] rxd_ff, nxt_rxd;
  logic rxv_ff, nxt_rxv;
  always_comb begin
    nxt_rxd = rxd_ff;
    nxt_rxv = rxv_ff && !rx_ready_i;
    if (rq_valid && rx_ready_i && !rxv_ff) begin
      nxt_rxd = rq_data;
      nxt_rxv = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rxd_ff <= '0;
      rxv_ff <= 1'b0;
    end else begin
      rxd_ff <= nxt_rxd;
      rxv_ff <= nxt_rxv;
    end
  end

  // Transmit encoder: one word at a time, MSB first.
  logic [RCW-1:0] tcnt_ff, nxt_tcnt;
  logic [W-1:0] tsh_ff, nxt_tsh;
  logic [BW-1:0] tbits_ff, nxt_tbits;
  logic tbusy_ff, nxt_tbusy;
  logic tline_ff, nxt_tline;
  logic tdrv_ff, nxt_tdrv;
  logic tready_ff, nxt_tready;

  always_comb begin
    nxt_tcnt = tcnt_ff;
    nxt_tsh = tsh_ff;
    nxt_tbits = tbits_ff;
    nxt_tbusy = tbusy_ff;
    nxt_tline = tline_ff;
    nxt_tdrv = tbusy_ff;
    nxt_tready = !tbusy_ff && mode_ff == BPL_PROG && !tready_ff;
    if (!tbusy_ff) begin
      if (tready_ff && tx_valid_i) begin
        nxt_tsh = tx_data_i;
        nxt_tbits = '0;
        nxt_tcnt = '0;
        nxt_tbusy = 1'b1;
        nxt_tready = 1'b0;
        nxt_tline = !tline_ff; // Opening boundary edge.
      end
    end else begin
      nxt_tcnt = tick(tcnt_ff);
      if (tcnt_ff == TX_HALF - 1'b1 && tsh_ff[W-1]) begin
        nxt_tline = !tline_ff;
      end
      if (tcnt_ff == TX_FULL - 1'b1) begin
        nxt_tline = !tline_ff;
        nxt_tcnt = '0;
        nxt_tsh = {tsh_ff[W-2:0], 1'b0};
        if (tbits_ff == BW'(W - 1)) begin
          nxt_tbusy = 1'b0;
        end else begin
          nxt_tbits = tbits_ff + 1'b1;
        end
      end
    end
    // Drive rises with the opening edge and falls a cycle after the closing one.
    nxt_tdrv = nxt_tdrv || nxt_tbusy;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tcnt_ff <= '0;
      tsh_ff <= '0;
      tbits_ff <= '0;
      tbusy_ff <= 1'b0;
      tline_ff <= 1'b1;
      tdrv_ff <= 1'b0;
      tready_ff <= 1'b0;
    end else begin
      tcnt_ff <= nxt_tcnt;
      tsh_ff <= nxt_tsh;
      tbits_ff <= nxt_tbits;
      tbusy_ff <= nxt_tbusy;
      tline_ff <= nxt_tline;
      tdrv_ff <= nxt_tdrv;
      tready_ff <= nxt_tready;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    tx_line_o = tline_ff;
    tx_drive_o = tdrv_ff;
    prog_mode_o = (mode_ff == BPL_PROG);
    lock_pending_o = lock_pend_ff;
    rx_data_o = rxd_ff;
    rx_valid_o = rxv_ff;
    tx_ready_o = tready_ff;
    diag_o = diag_ff;
    rx_err_cnt_o = rerr_ff;
  end
endmodule : bpl_link
`default_nettype wire

// >>> bpl_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module bpl_link_props #(
  parameter int unsigned W = 8,
  parameter int unsigned REPLY_CYC = 40
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic lock_nv_i,
  input wire logic prog_pulse_i,
  input wire logic lock_write_i,
  input wire logic tx_line_o,
  input wire logic tx_drive_o,
  input wire logic prog_mode_o,
  input wire logic lock_pending_o,
  input wire logic [W-1:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] diag_i,
  input wire logic [7:0] diag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic last_ff;
  logic seen_ff;
  logic [15:0] gap_ff;
  // Measures the spacing of reply line edges once a reply has opened.
  always_ff @(posedge clk_i) begin
    last_ff <= tx_line_o;
    seen_ff <= tx_drive_o && (seen_ff || tx_line_o != last_ff);
    gap_ff <= (tx_line_o != last_ff) ? 16'h1 : gap_ff + 16'h1;
  end
  // Mode, lock, reply timing, diagnostics and receive stream.
  a_reset_idle: assert property (
    $fell(sys_rst_i) |-> tx_line_o && !tx_drive_o && !prog_mode_o && !lock_pending_o)
    else $error("outputs not idle after reset");
  a_app_silent: assert property (!prog_mode_o |-> !rx_valid_o)
    else $error("word delivered in application mode");
  a_prog_entry: assert property (
    !prog_mode_o && prog_pulse_i && !lock_nv_i && !$past(sys_rst_i) && !$past(sys_rst_i, 2)
    |-> ##[1:2] prog_mode_o)
    else $error("unlocked part did not enter programming mode");
  a_lock_blocks: assert property (!prog_mode_o && lock_nv_i |=> !prog_mode_o)
    else $error("locked part entered programming mode");
  a_lock_later: assert property (
    prog_mode_o && lock_write_i |=> prog_mode_o && lock_pending_o)
    else $error("lock write acted at once");
  a_tx_edge_gap: assert property (
    seen_ff && tx_line_o != last_ff |-> gap_ff == REPLY_CYC / 2 || gap_ff == REPLY_CYC)
    else $error("reply edge off the bit grid");
  a_tx_max_gap: assert property (tx_drive_o && seen_ff |-> gap_ff <= REPLY_CYC)
    else $error("reply bit without closing edge");
  a_diag_delay: assert property (!sys_rst_i |=> diag_o == $past(diag_i))
    else $error("diagnostic value not passed through");
  a_rx_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received word dropped while stalled");
endmodule : bpl_link_props
`default_nettype wire

// >>> bpl_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpl_prog_model #(
  parameter int unsigned BIT = 40
) (
  input wire logic clk_i,
  input wire logic tx_line_i,
  input wire logic tx_drive_i,
  output logic line_o,
  output logic [7:0] word_o,
  output logic word_stb_o
);
  logic prev;
  logic mid;
  logic [7:0] sh;
  int cnt;
  int nb;
  initial begin
    line_o = 1'b1;
    word_o = 8'h00;
    word_stb_o = 1'b0;
  end
  // Sends one word MSB first; an edge opens it and two idle bits close it.
  task automatic send(input logic [7:0] w);
    line_o <= ~line_o;
    for (int i = 7; i >= 0; i--) begin
      repeat (BIT / 2) @(posedge clk_i);
      if (w[i]) line_o <= ~line_o;
      repeat (BIT / 2) @(posedge clk_i);
      line_o <= ~line_o;
    end
    repeat (2 * BIT) @(posedge clk_i);
  endtask : send
  // Two edges far too close together, as a disturbed line would show.
  task automatic glitch();
    line_o <= ~line_o;
    repeat (3) @(posedge clk_i);
    line_o <= ~line_o;
    repeat (2 * BIT) @(posedge clk_i);
  endtask : glitch
  // Decodes replies by timing each edge from the last bit boundary.
  always @(posedge clk_i) begin
    prev <= tx_line_i;
    word_stb_o <= 1'b0;
    cnt <= cnt + 1;
    if (!tx_drive_i) begin
      nb <= -1;
    end else if (tx_line_i != prev) begin
      if (nb >= 0 && cnt < 3 * BIT / 4) begin
        mid <= 1'b1;
      end else begin
        cnt <= 1;
        mid <= 1'b0;
        nb <= (nb == 7) ? -1 : nb + 1;
        if (nb >= 0) sh <= {sh[6:0], mid};
        if (nb == 7) word_o <= {sh[6:0], mid};
        if (nb == 7) word_stb_o <= 1'b1;
      end
    end
  end
endmodule : bpl_prog_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BIT = 40;
  logic clk_i, sys_rst_i, lock_nv_i, prog_pulse_i, rx_line, tx_line, tx_drive;
  logic prog_mode, lock_pending, lock_write, rx_valid, rx_ready, tx_valid, tx_ready, mstb;
  logic [7:0] rx_data, tx_data, diag_i, diag_o, err_cnt, mw, w;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int mismatches = 0;
  int checks_done = 0;
  bpl_link #(.HOST_CYC(BIT), .REPLY_CYC(BIT)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .lock_nv_i(lock_nv_i), .prog_pulse_i(prog_pulse_i), .rx_line_i(rx_line),
    .tx_line_o(tx_line), .tx_drive_o(tx_drive), .prog_mode_o(prog_mode),
    .lock_pending_o(lock_pending), .lock_write_i(lock_write), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .diag_i(diag_i), .diag_o(diag_o), .rx_err_cnt_o(err_cnt));
  bpl_prog_model #(.BIT(BIT)) partner (.clk_i(clk_i), .tx_line_i(tx_line),
    .tx_drive_i(tx_drive), .line_o(rx_line), .word_o(mw), .word_stb_o(mstb));
  // Free-running clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic do_reset(input logic lk);
    sys_rst_i <= 1'b1;
    lock_nv_i <= lk;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  task automatic pulse_prog();
    prog_pulse_i <= 1'b1;
    @(posedge clk_i);
    prog_pulse_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse_prog
  task automatic drain();
    for (int k = 0; k < 20000 && rxq.size() + txq.size() > 0; k++) @(posedge clk_i);
    check(8'(rxq.size() + txq.size()), 8'h00);
    if (rxq.size() + txq.size() > 0) complete_run();
  endtask : drain
  // Offers one reply word and holds it until the block takes it.
  task automatic send_reply(input logic [7:0] d);
    int k;
    tx_data <= d;
    tx_valid <= 1'b1;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk_i);
      if (tx_ready) break;
    end
    txq.push_back(d);
    if (k == 1000) begin
      mismatches++;
      complete_run();
    end
  endtask : send_reply
  // Random stalls and diagnostics; every word seen is matched against its queue.
  always @(posedge clk_i) begin
    rx_ready <= 1'($urandom_range(0, 1));
    diag_i <= 8'($urandom);
    if (rx_valid && rx_ready) check(rx_data, rxq.size() > 0 ? rxq.pop_front() : 8'hxx);
    if (mstb) check(mw, txq.size() > 0 ? txq.pop_front() : 8'hxx);
  end
  // Main sequence.
  initial begin
    {prog_pulse_i, lock_write, tx_valid, rx_ready} = 4'h0;
    {tx_data, diag_i} = 16'h0000;
    void'($urandom(32'hb6dafe07));
    do_reset(1'b0);
    partner.send(8'ha5);
    check(prog_mode, 1'b0);
    $display("test app_mode done");
    pulse_prog();
    check(prog_mode, 1'b1);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      rxq.push_back(w);
      partner.send(w);
    end
    drain();
    $display("test receive done");
    for (int i = 0; i < 5; i++) begin
      send_reply((i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom));
    end
    tx_valid <= 1'b0;
    @(posedge clk_i);
    check(tx_drive, 1'b1);
    drain();
    check(err_cnt, 8'h00);
    partner.glitch();
    check(err_cnt, 8'h01);
    $display("test reply done");
    lock_write <= 1'b1;
    @(posedge clk_i);
    lock_write <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(lock_pending, 1'b1);
    check(prog_mode, 1'b1);
    do_reset(1'b1);
    check(lock_pending, 1'b0);
    pulse_prog();
    check(prog_mode, 1'b0);
    partner.send(8'h3c);
    check(tx_drive, 1'b0);
    $display("test lock done");
    complete_run();
  end
endmodule : testbench
bind bpl_link bpl_link_props #(.W(W), .REPLY_CYC(REPLY_CYC)) chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .lock_nv_i(lock_nv_i), .prog_pulse_i(prog_pulse_i),
  .lock_write_i(lock_write_i), .tx_line_o(tx_line_o), .tx_drive_o(tx_drive_o),
  .prog_mode_o(prog_mode_o), .lock_pending_o(lock_pending_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .diag_i(diag_i), .diag_o(diag_o));
`default_nettype wire
